//--- shared/sep_pkg.sv
package sep_pkg;

  // ****************************************************************
  // Widths, FIFO depth and bit positions
  // ****************************************************************
  localparam int ADDR_W     = 9;              // Byte address width, two blocks of 256.
  localparam int BYTE_W     = 8;              // Serial byte width.
  localparam int WR_W       = ADDR_W + BYTE_W; // FIFO word: address above data.
  localparam int FIFO_DEPTH = 4;              // Words held in the write FIFO.
  localparam int SEL_RW     = 0;              // Select byte read/write bit.
  localparam int SEL_BLK    = 1;              // Select byte block bit.
  localparam int SEL_CE_LO  = 2;              // Select byte low chip enable bit.
  localparam int SEL_CE_HI  = 3;              // Select byte high chip enable bit.
  localparam int SEL_TYPE   = 4;              // Lowest bit of the type code.
  localparam int P_CE_LO    = 0;              // Strap vector: low chip enable.
  localparam int P_CE_HI    = 1;              // Strap vector: high chip enable.
  localparam int P_MODE     = 2;              // Strap vector: burst mode strap.
  localparam int P_LOCK     = 3;              // Strap vector: write lock input.
  localparam int P_PRE      = 4;              // Strap vector: protect enable.
  localparam int L_SCL      = 0;              // Line vector: serial clock.
  localparam int L_SDA      = 1;              // Line vector: serial data.
  localparam int L_POR      = 2;              // Line vector: power-on reset.

  // ****************************************************************
  // Counts, burst masks and reset values
  // ****************************************************************
  localparam logic [3:0]        RX_LAST   = 4'h8;   // Bits in a received byte.
  localparam logic [3:0]        TX_LAST   = 4'h7;   // Count at the fall after the last sent bit.
  localparam logic [ADDR_W-1:0] MULTI_MSK = 9'h003; // Four byte burst wrap.
  localparam logic [ADDR_W-1:0] PAGE_MSK  = 9'h007; // Eight byte burst wrap.
  localparam logic [ADDR_W-1:0] PTR_RST   = 9'h000; // Pointer after reset.
  localparam logic [2:0]        LINE_IDLE = 3'h3;   // Line sync idle: no power-on reset, data and clock high.
  localparam logic [1:0]        EDGE_IDLE = 2'h3;   // Delayed data and clock idle high.

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,  // Waiting for START.
    ST_DEV  = 3'b001,  // Receiving the select byte.
    ST_ADR  = 3'b010,  // Receiving the byte address.
    ST_WDAT = 3'b011,  // Receiving write data.
    ST_RDAT = 3'b100,  // Sending read data.
    ST_MACK = 3'b101,  // Master acknowledge slot.
    ST_WAIT = 3'b110,  // Released until STOP or START.
    ST_PROG = 3'b111   // Programming, bus ignored.
  } sep_state_t;

  typedef struct packed {
    logic [2:0]        ln1;    // Line sync, first stage.
    logic [2:0]        ln2;    // Line sync, second stage.
    logic [1:0]        ln3;    // Delayed scl and sda for edges.
    logic [4:0]        pn1;    // Strap sync, first stage.
    logic [4:0]        pn2;    // Strap sync, second stage.
    sep_state_t        st;     // Bus state.
    logic              ackp;   // Acknowledge phase or master nack.
    logic [3:0]        cnt;    // Bit counter.
    logic [BYTE_W-1:0] sh;     // Shift register.
    logic              oe;     // Data line pulled low.
    logic              dl;     // Data line output level.
    logic [ADDR_W-1:0] ptr;    // Internal address pointer.
    logic              wr_any; // A byte was queued this write.
    logic              go;     // Programming start pulse.
    logic              busy;   // Programming in progress.
    logic              push;   // FIFO push strobe.
    logic [WR_W-1:0]   pdat;   // FIFO push word.
  } sep_core_t;

endpackage : sep_pkg

//--- shared/sep_stream_if.sv
`timescale 1ns/1ps
// Valid/ready stream between the bus front end and the write FIFO.
interface sep_stream_if #(
  parameter int W = 17
);
  logic         valid;  // Word offered.
  logic         ready;  // Word can be taken.
  logic [W-1:0] data;   // Word.

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : sep_stream_if

//--- src/sep_fifo.sv
`timescale 1ns/1ps
module sep_fifo #(
  parameter int W = 17,
  parameter int D = 4
) (
  input  wire logic   clk,
  input  wire logic   rst,
  sep_stream_if.snk   in_s,
  output logic [W-1:0] o_data,
  output logic         o_valid,
  input  wire logic    o_ready,
  output logic         empty
);

  // ****************************************************************
  // State
  // ****************************************************************
  localparam int PW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;  // Storage words.
    logic [PW-1:0]       wp;   // Write pointer.
    logic [PW-1:0]       rp;   // Read pointer.
    logic [PW:0]         n;    // Words in storage.
    logic                ov;   // Output register holds a word.
    logic [W-1:0]        od;   // Output register.
  } sep_fifo_t;

  sep_fifo_t r_r;    // Registered state.
  sep_fifo_t r_nxt;  // Next state.
  logic      put;    // Word accepted.
  logic      take;   // Word moved to output register.

  // Storage is full only when every slot holds a word.
  assign in_s.ready = (r_r.n != (PW+1)'(D));
  assign put        = in_s.valid & in_s.ready;
  assign take       = (r_r.n != '0) & (~r_r.ov | o_ready);
  assign o_data     = r_r.od;
  assign o_valid    = r_r.ov;
  assign empty      = (r_r.n == '0) & ~r_r.ov;

  // Next state: store, refill output, count.
  always_comb begin
    r_nxt = r_r;
    if (put) begin
      r_nxt.mem[r_r.wp] = in_s.data;
      r_nxt.wp          = (r_r.wp == PW'(D-1)) ? '0 : r_r.wp + 1'b1;
    end
    if (take) begin
      r_nxt.od = r_r.mem[r_r.rp];
      r_nxt.ov = 1'b1;
      r_nxt.rp = (r_r.rp == PW'(D-1)) ? '0 : r_r.rp + 1'b1;
    end else if (o_ready) begin
      r_nxt.ov = 1'b0;
    end
    r_nxt.n = r_r.n + (PW+1)'(put) - (PW+1)'(take);
  end

  // State register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

endmodule : sep_fifo

//--- src/sep_front.sv
`timescale 1ns/1ps
// ****************************************************************
// ****************************************************************
module sep_front #(
  parameter logic [3:0] TYPE_CODE = 4'h6,  // Arbitrary type code value.
  parameter bit         HW_LOCK   = 1'b0   // Write lock variant, no four byte mode.
) (
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  input  wire logic                       scl,
  input  wire logic                       sda_i,
  output logic                            sda_o,
  output logic                            sda_oe,
  input  wire logic                       por_active,
  input  wire logic                       select_strap_low,
  input  wire logic                       select_strap_high,
  input  wire logic                       mode_strap,
  input  wire logic                       write_lock_input,
  input  wire logic                       protect_en,
  input  wire logic                       prot_ptr_bit,
  output logic [sep_pkg::ADDR_W-1:0]      mem_addr,
  input  wire logic [sep_pkg::BYTE_W-1:0] mem_rdata,
  output logic                            wr_valid,
  input  wire logic                       wr_ready,
  output logic [sep_pkg::WR_W-1:0]        wr_word,
  output logic                            prog_start,
  output logic                            prog_busy_o,
  input  wire logic                       prog_busy
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  sep_pkg::sep_core_t r_r;        // Registered state.
  sep_pkg::sep_core_t r_nxt;      // Next state.
  logic               scl_rise;   // Serial clock rising edge.
  logic               scl_fall;   // Serial clock falling edge.
  logic               start_det;  // START seen.
  logic               stop_det;   // STOP seen.
  logic               sda_s;      // Synchronised data line.
  logic               sel_ok;     // Select byte addresses this device.
  logic               locked;     // Writes are blocked.
  logic [sep_pkg::ADDR_W-1:0] wmsk; // Burst wrap mask.
  logic               fifo_empty; // No write word pending.

  sep_stream_if #(.W(sep_pkg::WR_W)) push_s ();

  // Wrapped increment of the pointer within a mask.
  function automatic logic [sep_pkg::ADDR_W-1:0] wrap_inc(
    input logic [sep_pkg::ADDR_W-1:0] p,
    input logic [sep_pkg::ADDR_W-1:0] m
  );
    logic [sep_pkg::ADDR_W-1:0] q;
    q = p + 1'b1;
    return (p & ~m) | (q & m);
  endfunction : wrap_inc

  // ****************************************************************
  // Edge and condition detect
  // ****************************************************************
  // Only the second sync stage and its delayed copy feed logic.
  assign sda_s     = r_r.ln2[sep_pkg::L_SDA];
  assign scl_rise  = r_r.ln2[sep_pkg::L_SCL] & ~r_r.ln3[sep_pkg::L_SCL];
  assign scl_fall  = ~r_r.ln2[sep_pkg::L_SCL] & r_r.ln3[sep_pkg::L_SCL];
  assign start_det = r_r.ln2[sep_pkg::L_SCL] & r_r.ln3[sep_pkg::L_SCL]
                   & r_r.ln3[sep_pkg::L_SDA] & ~sda_s;
  assign stop_det  = r_r.ln2[sep_pkg::L_SCL] & r_r.ln3[sep_pkg::L_SCL]
                   & ~r_r.ln3[sep_pkg::L_SDA] & sda_s;

  // Type code and both enable straps must match the received byte.
  assign sel_ok = (r_r.sh[7:sep_pkg::SEL_TYPE] == TYPE_CODE)
                & (r_r.sh[sep_pkg::SEL_CE_HI] == r_r.pn2[sep_pkg::P_CE_HI])
                & (r_r.sh[sep_pkg::SEL_CE_LO] == r_r.pn2[sep_pkg::P_CE_LO]);

  // Writes are locked by the lock strap, or by protect enable with the protect pointer bit set in the upper block.
  assign locked = r_r.pn2[sep_pkg::P_LOCK]
                | (r_r.pn2[sep_pkg::P_PRE] & prot_ptr_bit & r_r.ptr[sep_pkg::ADDR_W-1]);

  // The lock variant offers only page bursts.
  assign wmsk = (r_r.pn2[sep_pkg::P_MODE] & ~HW_LOCK) ? sep_pkg::MULTI_MSK
                                                      : sep_pkg::PAGE_MSK;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    r_nxt      = r_r;
    r_nxt.ln1  = {por_active, sda_i, scl};
    r_nxt.ln2  = r_r.ln1;
    r_nxt.ln3  = r_r.ln2[1:0];
    r_nxt.pn1  = {protect_en, write_lock_input, mode_strap, select_strap_high, select_strap_low};
    r_nxt.pn2  = r_r.pn1;
    r_nxt.dl   = 1'b0;
    r_nxt.go   = 1'b0;
    r_nxt.push = 1'b0;
    if (r_r.ln2[sep_pkg::L_POR]) begin
      // Power-on reset holds the front end idle and released.
      r_nxt.st   = sep_pkg::ST_IDLE;
      r_nxt.oe   = 1'b0;
      r_nxt.ackp = 1'b0;
      r_nxt.busy = 1'b0;
    end else if (r_r.st == sep_pkg::ST_PROG) begin
      // Programming runs until the FIFO drains and storage is done.
      if (fifo_empty && !prog_busy) begin
        r_nxt.st   = sep_pkg::ST_IDLE;
        r_nxt.busy = 1'b0;
      end
    end else if (start_det) begin
      // START or repeated START opens a new select byte.
      r_nxt.st     = sep_pkg::ST_DEV;
      r_nxt.cnt    = '0;
      r_nxt.ackp   = 1'b0;
      r_nxt.oe     = 1'b0;
      r_nxt.wr_any = 1'b0;
    end else if (stop_det) begin
      // STOP ends the transfer; a queued write starts programming.
      r_nxt.oe   = 1'b0;
      r_nxt.ackp = 1'b0;
      if (r_r.st == sep_pkg::ST_WDAT && r_r.wr_any) begin
        r_nxt.st   = sep_pkg::ST_PROG;
        r_nxt.go   = 1'b1;
        r_nxt.busy = 1'b1;
      end else begin
        r_nxt.st = sep_pkg::ST_IDLE;
      end
    end else begin
      unique case (r_r.st)
        sep_pkg::ST_IDLE, sep_pkg::ST_WAIT, sep_pkg::ST_PROG: begin
          // Released; nothing moves until START or STOP.
          r_nxt.oe = 1'b0;
        end
        sep_pkg::ST_DEV, sep_pkg::ST_ADR, sep_pkg::ST_WDAT: begin
          if (scl_rise && !r_r.ackp) begin
            // Bits are taken most significant first on the rise.
            r_nxt.sh  = {r_r.sh[6:0], sda_s};
            r_nxt.cnt = r_r.cnt + 1'b1;
          end else if (scl_fall && !r_r.ackp && r_r.cnt == sep_pkg::RX_LAST) begin
            // Decide the ninth bit answer.
            r_nxt.ackp = 1'b1;
            r_nxt.oe   = 1'b1;
            if (r_r.st == sep_pkg::ST_DEV && !sel_ok) begin
              r_nxt.st   = sep_pkg::ST_WAIT;
              r_nxt.oe   = 1'b0;
              r_nxt.ackp = 1'b0;
            end else if (r_r.st == sep_pkg::ST_DEV) begin
              r_nxt.ptr[sep_pkg::ADDR_W-1] = r_r.sh[sep_pkg::SEL_BLK];
            end else if (r_r.st == sep_pkg::ST_WDAT && !locked) begin
              if (push_s.ready) begin
                // Queue address and data for the storage side.
                r_nxt.push   = 1'b1;
                r_nxt.pdat   = {r_r.ptr, r_r.sh};
                r_nxt.wr_any = 1'b1;
              end else begin
                r_nxt.st   = sep_pkg::ST_WAIT;
                r_nxt.oe   = 1'b0;
                r_nxt.ackp = 1'b0;
              end
            end
          end else if (scl_fall && r_r.ackp) begin
            // End of the ninth bit: release and move on.
            r_nxt.ackp = 1'b0;
            r_nxt.oe   = 1'b0;
            r_nxt.cnt  = '0;
            unique case (r_r.st)
              sep_pkg::ST_DEV: begin
                if (r_r.sh[sep_pkg::SEL_RW]) begin
                  // Read: drive the first bit from the pointer.
                  r_nxt.st = sep_pkg::ST_RDAT;
                  r_nxt.sh = mem_rdata;
                  r_nxt.oe = ~mem_rdata[7];
                end else begin
                  r_nxt.st = sep_pkg::ST_ADR;
                end
              end
              sep_pkg::ST_ADR: begin
                r_nxt.ptr[sep_pkg::BYTE_W-1:0] = r_r.sh;
                r_nxt.st = sep_pkg::ST_WDAT;
              end
              default: begin
                // Burst address wraps inside its group.
                r_nxt.ptr = wrap_inc(r_r.ptr, wmsk);
              end
            endcase
          end
        end
        sep_pkg::ST_RDAT: begin
          if (scl_fall) begin
            if (r_r.cnt == sep_pkg::TX_LAST) begin
              // Eighth bit done: release for the master answer.
              r_nxt.oe  = 1'b0;
              r_nxt.st  = sep_pkg::ST_MACK;
              r_nxt.cnt = '0;
              r_nxt.ptr = r_r.ptr + 1'b1;
            end else begin
              r_nxt.oe  = ~r_r.sh[6];
              r_nxt.sh  = {r_r.sh[6:0], 1'b0};
              r_nxt.cnt = r_r.cnt + 1'b1;
            end
          end
        end
        sep_pkg::ST_MACK: begin
          if (scl_rise) begin
            r_nxt.ackp = sda_s;
          end else if (scl_fall) begin
            if (r_r.ackp) begin
              // Nack: wait released for STOP.
              r_nxt.st   = sep_pkg::ST_WAIT;
              r_nxt.ackp = 1'b0;
            end else begin
              r_nxt.st = sep_pkg::ST_RDAT;
              r_nxt.sh = mem_rdata;
              r_nxt.oe = ~mem_rdata[7];
            end
          end
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      r_r     <= '0;
      r_r.ptr <= sep_pkg::PTR_RST;
      // Line samples start at their idle level, so no false edge follows reset.
      r_r.ln1 <= sep_pkg::LINE_IDLE;
      r_r.ln2 <= sep_pkg::LINE_IDLE;
      r_r.ln3 <= sep_pkg::EDGE_IDLE;
    end else begin
      r_r <= r_nxt;
    end
  end

  // ****************************************************************
  // Write FIFO
  // ****************************************************************
  assign push_s.valid = r_r.push;
  assign push_s.data  = r_r.pdat;

  sep_fifo #(
    .W (sep_pkg::WR_W),
    .D (sep_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk     (sys_clk),
    .rst     (rst),
    .in_s    (push_s),
    .o_data  (wr_word),
    .o_valid (wr_valid),
    .o_ready (wr_ready),
    .empty   (fifo_empty)
  );

  assign sda_o       = r_r.dl;
  assign sda_oe      = r_r.oe;
  assign mem_addr    = r_r.ptr;
  assign prog_start  = r_r.go;
  assign prog_busy_o = r_r.busy;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_stop_write;
    (r_r.st == sep_pkg::ST_WDAT) && r_r.wr_any && stop_det && !r_r.ln2[sep_pkg::L_POR];
  endsequence

  sequence s_nack_seen;
    (r_r.st == sep_pkg::ST_MACK) && r_r.ackp && scl_fall && !start_det && !stop_det
      && !r_r.ln2[sep_pkg::L_POR];
  endsequence

  sequence s_wait_stop;
    (r_r.st == sep_pkg::ST_WAIT) && stop_det && !r_r.ln2[sep_pkg::L_POR];
  endsequence

  // Power-on reset leaves the line released and the machine idle.
  por_quiet_a: assert property (r_r.ln2[sep_pkg::L_POR] |=> !sda_oe && r_r.st == sep_pkg::ST_IDLE)
    else $error("bus active during power-on reset");

  // The data line is only ever pulled low.
  drive_low_a: assert property (sda_oe |-> sda_o == 1'b0)
    else $error("data line driven high");

  // Only a matching select byte is acknowledged.
  sel_match_a: assert property ($rose(sda_oe) && r_r.st == sep_pkg::ST_DEV |-> $past(sel_ok))
    else $error("select acknowledged without match");

  // The acknowledge stands until the serial clock falls again.
  ack_hold_a: assert property (r_r.ackp && sda_oe && !scl_fall && !start_det && !stop_det
                               && !r_r.ln2[sep_pkg::L_POR] && r_r.st != sep_pkg::ST_MACK |=> sda_oe)
    else $error("acknowledge dropped early");

  // A write closed by STOP gives one start pulse and enters programming.
  prog_go_a: assert property (s_stop_write
                              |=> prog_start && r_r.st == sep_pkg::ST_PROG ##1 !prog_start)
    else $error("write stop did not start programming");

  // Programming holds while the storage side reports busy.
  prog_hold_a: assert property (r_r.st == sep_pkg::ST_PROG && prog_busy && !r_r.ln2[sep_pkg::L_POR]
                                |=> r_r.st == sep_pkg::ST_PROG && prog_busy_o)
    else $error("programming ended while storage busy");

  // A START during programming opens nothing.
  prog_deaf_a: assert property (r_r.st == sep_pkg::ST_PROG && start_det |=> r_r.st != sep_pkg::ST_DEV)
    else $error("start accepted while programming");

  // A master nack leaves the line released, waiting for STOP.
  nack_stop_a: assert property (s_nack_seen |=> r_r.st == sep_pkg::ST_WAIT && !sda_oe)
    else $error("nack did not release the line");

  // STOP while waiting returns the machine to standby.
  wait_stop_a: assert property (s_wait_stop |=> r_r.st == sep_pkg::ST_IDLE)
    else $error("stop did not reach standby");

  // A locked data byte is acknowledged but never queued.
  lock_skip_a: assert property (r_r.st == sep_pkg::ST_WDAT && scl_fall && !r_r.ackp
                                && r_r.cnt == sep_pkg::RX_LAST && locked && !start_det && !stop_det
                                && !r_r.ln2[sep_pkg::L_POR] |=> !r_r.push && sda_oe)
    else $error("locked byte was queued");

  // The block bit of the select byte lands in the pointer.
  blk_bit_a: assert property ($rose(sda_oe) && r_r.st == sep_pkg::ST_DEV
                              |-> mem_addr[sep_pkg::ADDR_W-1] == r_r.sh[sep_pkg::SEL_BLK])
    else $error("block bit not copied to pointer");

  // Each sent byte advances the pointer by one.
  seq_inc_a: assert property ($changed(r_r.st) && r_r.st == sep_pkg::ST_MACK
                              |-> mem_addr == $past(mem_addr) + 1'b1)
    else $error("read pointer did not advance");

endmodule : sep_front

//--- test/sep_master.sv
`timescale 1ns/1ps
// Two-wire bus master, 48 ns serial clock, open drain on the data line.
module sep_master (
  output logic     scl,
  output logic     sda_low,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Data moves only while the clock is low.
  task automatic bitx(input logic b, output logic r);
    sda_low = ~b;
    #12 scl = 1'b1;
    #12 r = sda;
    #12 scl = 1'b0;
    #12;
  endtask : bitx
  // START, also usable as a repeated START.
  task automatic start();
    sda_low = 1'b0;
    #24 scl = 1'b1;
    #24 sda_low = 1'b1;
    #24 scl = 1'b0;
    #24;
  endtask : start
  // STOP closes a transfer; a repeated START can end one instead.
  task automatic stop();
    sda_low = 1'b1;
    #24 scl = 1'b1;
    #24 sda_low = 1'b0;
    #24;
  endtask : stop
  // Byte out, most significant bit first, then the ack slot.
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask : wbyte
  // Byte in; the master acks in the ninth slot unless it is the last.
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(last, r);
  endtask : rbyte
endmodule : sep_master

//--- test/serial_eeprom_slave_front_end_test.sv
`timescale 1ns/1ps
module serial_eeprom_slave_front_end_test;
  localparam logic [3:0] TC = 4'h9;  // Arbitrary type code value.
  logic sys_clk = 1'b0, rst = 1'b1, por = 1'b0, lock = 1'b0, sda_o, sda_oe, wr_valid, ps, pb, scl, m_low, a;
  logic mode = 1'b1, pre = 1'b0, ppb = 1'b0, sbusy = 1'b0;  // Straps and storage busy, set per test.
  logic [8:0] mem_addr;
  logic [7:0] mem_rdata = 8'h00, d0, d1, d2, rd;
  logic [16:0] wr_word;
  logic [16:0] exp_q[$];
  int error_cnt = 0, num_checks = 0;
  wire sda = (sda_oe ? sda_o : 1'b1) & ~m_low;  // Pull-up when released.
  sep_master m_u (.scl(scl), .sda_low(m_low), .sda(sda));
  sep_front #(.TYPE_CODE(TC)) dut_u (.sys_clk(sys_clk), .rst(rst), .scl(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .por_active(por), .select_strap_low(1'b1), .select_strap_high(1'b0), .mode_strap(mode),
    .write_lock_input(lock), .protect_en(pre), .prot_ptr_bit(ppb), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .wr_valid(wr_valid), .wr_ready(1'b1), .wr_word(wr_word), .prog_start(ps), .prog_busy_o(pb), .prog_busy(sbusy));
  initial forever #2.5 sys_clk = ~sys_clk;
  // Storage side returns a pattern tied to the pointer.
  always @(posedge sys_clk) mem_rdata <= mem_addr[7:0] ^ {8{mem_addr[8]}};
  function automatic logic [7:0] pat(input logic [8:0] ad);
    return ad[7:0] ^ {8{ad[8]}};
  endfunction : pat
  function automatic logic [7:0] sel(input logic ce, input logic blk, input logic rw);
    return {TC, 1'b0, ce, blk, rw};
  endfunction : sel
  task automatic chk(input logic [16:0] s, input logic [16:0] e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  // Every queued word is compared with the oldest note.
  always @(negedge sys_clk) begin
    if (wr_valid) begin
      if (exp_q.size() == 0) chk(wr_word, 17'h1FFFF);
      else chk(wr_word, exp_q.pop_front());
    end
  end
  initial begin
    #100000;
    error_cnt++;
    test_done();
  end
  initial begin
    void'($urandom(32'h7082caa4));
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (10) @(posedge sys_clk);
    d0 = $urandom();
    d1 = $urandom();
    d2 = $urandom();
    sbusy <= 1'b1;
    exp_q.push_back({9'h1FE, d0});
    exp_q.push_back({9'h1FF, d1});
    exp_q.push_back({9'h1FC, d2});
    m_u.start();
    m_u.wbyte(sel(1'b1, 1'b1, 1'b0), a);
    chk(a, 1);
    m_u.wbyte(8'hFE, a);
    m_u.wbyte(d0, a);
    m_u.wbyte(d1, a);
    m_u.wbyte(d2, a);
    chk(a, 1);
    fork
      m_u.stop();
      begin
        @(posedge ps);
        @(negedge sys_clk);
        chk(pb, 1);
      end
    join
    m_u.start();
    m_u.wbyte(sel(1'b1, 1'b0, 1'b1), a);
    chk(a, 0);
    m_u.stop();
    @(negedge sys_clk) chk(pb, 1);
    @(posedge sys_clk) sbusy <= 1'b0;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk) chk(pb, 0);
    $display("test write done");
    m_u.start();
    m_u.wbyte(sel(1'b0, 1'b0, 1'b0), a);
    chk(a, 0);
    m_u.stop();
    $display("test mismatch done");
    m_u.start();
    m_u.wbyte(sel(1'b1, 1'b0, 1'b0), a);
    m_u.wbyte(8'h10, a);
    m_u.start();
    m_u.wbyte(sel(1'b1, 1'b0, 1'b1), a);
    m_u.rbyte(1'b0, rd);
    chk(rd, pat(9'h010));
    m_u.rbyte(1'b1, rd);
    chk(rd, pat(9'h011));
    m_u.stop();
    m_u.start();
    m_u.wbyte(sel(1'b1, 1'b0, 1'b1), a);
    m_u.rbyte(1'b1, rd);
    chk(rd, pat(9'h012));
    m_u.stop();
    $display("test read done");
    @(posedge sys_clk) mode <= 1'b0;
    exp_q.push_back({9'h006, d2});
    exp_q.push_back({9'h007, d1});
    exp_q.push_back({9'h000, d0});
    m_u.start();
    m_u.wbyte(sel(1'b1, 1'b0, 1'b0), a);
    m_u.wbyte(8'h06, a);
    m_u.wbyte(d2, a);
    m_u.wbyte(d1, a);
    m_u.wbyte(d0, a);
    chk(a, 1);
    m_u.stop();
    @(posedge sys_clk) mode <= 1'b1;
    $display("test page done");
    @(posedge sys_clk) pre <= 1'b1;
    ppb <= 1'b1;
    m_u.start();
    m_u.wbyte(sel(1'b1, 1'b1, 1'b0), a);
    m_u.wbyte(8'h30, a);
    m_u.wbyte(d0, a);
    chk(a, 1);
    m_u.stop();
    exp_q.push_back({9'h030, d1});
    m_u.start();
    m_u.wbyte(sel(1'b1, 1'b0, 1'b0), a);
    m_u.wbyte(8'h30, a);
    m_u.wbyte(d1, a);
    chk(a, 1);
    m_u.stop();
    @(posedge sys_clk) pre <= 1'b0;
    ppb <= 1'b0;
    $display("test protect done");
    @(posedge sys_clk) lock <= 1'b1;
    m_u.start();
    m_u.wbyte(sel(1'b1, 1'b0, 1'b0), a);
    m_u.wbyte(8'h20, a);
    m_u.wbyte(d0, a);
    chk(a, 1);
    m_u.stop();
    repeat (200) @(posedge sys_clk);
    lock <= 1'b0;
    por <= 1'b1;
    repeat (5) @(posedge sys_clk);
    m_u.start();
    m_u.wbyte(sel(1'b1, 1'b0, 1'b0), a);
    chk(a, 0);
    m_u.stop();
    @(posedge sys_clk) por <= 1'b0;
    repeat (5) @(posedge sys_clk);
    m_u.start();
    m_u.wbyte(sel(1'b1, 1'b0, 1'b1), a);
    chk(a, 1);
    m_u.rbyte(1'b1, rd);
    chk(rd, pat(9'h021));
    m_u.stop();
    chk(17'(exp_q.size()), 17'h0);
    $display("test lock and reset done");
    test_done();
  end
endmodule : serial_eeprom_slave_front_end_test
